// *** rtl/blc_params.svh ***
// Constants of the blit engine control register block: offsets, fields, reset values.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef BLC_PARAMS_SVH
`define BLC_PARAMS_SVH

`define BLC_CTRL_OFFSET 24'h400010
`define BLC_DATA_PORT_OFFSET 24'h400100

`define BLC_CTRL_RESET 32'h00000000
`define BLC_CTRL_WR_MASK 32'h007FF7FF

`define BLC_BUSY_BIT 31
`define BLC_PAT_ROW_LSB 20
`define BLC_SOLID_BIT 19
`define BLC_PAT_MONO_BIT 18
`define BLC_PAT_MASK_BIT 17
`define BLC_CMP_LSB 14
`define BLC_SRC_MASK_BIT 13
`define BLC_SRC_MONO_BIT 12
`define BLC_SRC_HOST_BIT 10
`define BLC_CORNER_LSB 8
`define BLC_ROP_LSB 0

`define BLC_HOST_MONO_BIT 0

`endif

// *** rtl/blc_pkg.sv ***
// Types shared by the blit engine control block.
// Assumes nothing of its surroundings.
package blc_pkg;

  typedef logic [23:0] blc_colour_t;

  typedef enum logic [1:0] {
    BLC_BPP8 = 2'h0,
    BLC_BPP16 = 2'h1,
    BLC_BPP24 = 2'h2
  } blc_bpp_t;

  typedef enum logic [1:0] {
    BLC_UPPER_LEFT = 2'h0,
    BLC_UPPER_RIGHT = 2'h1,
    BLC_LOWER_LEFT = 2'h2,
    BLC_LOWER_RIGHT = 2'h3
  } blc_corner_t;

  typedef enum {
    BLC_IDLE,
    BLC_RUN
  } blc_state_t;

endpackage

// *** rtl/blc_pix_if.sv ***
// Carrier between the control top and the per-pixel evaluator.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface blc_pix_if;
  import blc_pkg::*;
  logic solid_pat;
  logic pat_mono;
  logic pat_mask;
  logic [2:0] cmp;
  logic src_mask;
  logic src_mono;
  logic src_pair_sel;
  logic [7:0] rop;
  blc_bpp_t bpp;
  logic [7:0] pat_row_bits;
  logic [2:0] pat_col;
  blc_colour_t pat_colour;
  blc_colour_t pat_bg;
  blc_colour_t pat_fg;
  blc_colour_t src_bg;
  blc_colour_t src_fg;
  logic src_bit;
  blc_colour_t src_colour;
  blc_colour_t dst_colour;
  blc_colour_t result;
  logic we;

  modport ctl (
    output solid_pat, pat_mono, pat_mask, cmp, src_mask, src_mono, src_pair_sel, rop, bpp,
    output pat_row_bits, pat_col, pat_colour, pat_bg, pat_fg, src_bg, src_fg,
    output src_bit, src_colour, dst_colour,
    input result, we
  );

  modport eval (
    input solid_pat, pat_mono, pat_mask, cmp, src_mask, src_mono, src_pair_sel, rop, bpp,
    input pat_row_bits, pat_col, pat_colour, pat_bg, pat_fg, src_bg, src_fg,
    input src_bit, src_colour, dst_colour,
    output result, we
  );
endinterface

// *** rtl/blc_pixel.sv ***
// Per-pixel evaluator: operand expansion, raster operation and write masking.
// Assumes operands are stable in the cycle they are read; purely combinational.
`timescale 1ns/100ps
module blc_pixel (
  // Pixel operands and result
  blc_pix_if.eval pix
);
  import blc_pkg::*;

  logic pat_bit;
  blc_colour_t exp_bg;
  blc_colour_t exp_fg;
  blc_colour_t pat_op;
  blc_colour_t src_op;
  blc_colour_t rop_out;
  blc_colour_t depth_mask;
  blc_colour_t cmp_lhs;
  logic cmp_same;
  logic cmp_ok;
  logic pat_keep;
  logic src_keep;

  // Operand expansion
  always_comb begin
    pat_bit = pix.solid_pat ? 1'b0 : pix.pat_row_bits[pix.pat_col];
    exp_bg = pix.src_pair_sel ? pix.src_bg : pix.pat_bg;
    exp_fg = pix.src_pair_sel ? pix.src_fg : pix.pat_fg;
    pat_op = pix.pat_mono ? (pat_bit ? pix.pat_fg : pix.pat_bg) : pix.pat_colour;
    src_op = pix.src_mono ? (pix.src_bit ? exp_fg : exp_bg) : pix.src_colour;
  end

  // Raster operation per bit
  genvar b;
  generate
    for (b = 0; b < 24; b = b + 1) begin : g_rop
      assign rop_out[b] = pix.rop[{pat_op[b], src_op[b], pix.dst_colour[b]}];
    end
  endgenerate

  // Colour compare at engine depth
  always_comb begin
    unique case (pix.bpp)
      BLC_BPP8: depth_mask = 24'h0000FF;
      BLC_BPP16: depth_mask = 24'h00FFFF;
      default: depth_mask = 24'hFFFFFF;
    endcase
    cmp_lhs = pix.cmp[1] ? pix.dst_colour : rop_out;
    cmp_same = (cmp_lhs & depth_mask) == (exp_bg & depth_mask);
    cmp_ok = !pix.cmp[0] || (pix.cmp[2] ? cmp_same : !cmp_same);
  end

  // Write masking
  always_comb begin
    pat_keep = pix.pat_mask && pix.pat_mono && !pat_bit;
    src_keep = pix.src_mask && pix.src_mono && !pix.src_bit;
  end

  assign pix.result = rop_out & depth_mask;
  assign pix.we = cmp_ok && !pat_keep && !src_keep;

endmodule // blc_pixel

// *** rtl/blc_top.sv ***
// Blit engine control register and pixel sequencer.
// Assumes a memory-space register port and frame-buffer operands on the same clock.
`timescale 1ns/100ps
`include "blc_params.svh"
module blc_top #(
  parameter int DIM_W = 13
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Memory-space register access
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [23:0] i_mem_addr,
  input wire logic [3:0] i_mem_be,
  input wire logic [31:0] i_mem_wdata,
  output logic [31:0] o_mem_rdata,
  output logic o_data_port_ready,
  // Operation setup from the other engine registers
  input wire logic i_start,
  input wire logic [DIM_W-1:0] i_width_px,
  input wire logic [DIM_W-1:0] i_height,
  input wire logic [2:0] i_dst_addr_lo,
  input wire blc_pkg::blc_bpp_t i_bpp,
  input wire logic i_src_pair_sel,
  input wire blc_pkg::blc_colour_t i_pat_bg,
  input wire blc_pkg::blc_colour_t i_pat_fg,
  input wire blc_pkg::blc_colour_t i_src_bg,
  input wire blc_pkg::blc_colour_t i_src_fg,
  // Frame-buffer operands
  input wire logic i_pix_valid,
  input wire logic [7:0] i_pat_row_bits,
  input wire blc_pkg::blc_colour_t i_pat_colour,
  input wire logic i_fb_src_bit,
  input wire blc_pkg::blc_colour_t i_fb_src_colour,
  input wire blc_pkg::blc_colour_t i_dst_colour,
  // Fetch steering
  output logic o_busy,
  output logic o_pat_fetch_en,
  output logic o_src_fetch_fb,
  output logic o_x_step_neg,
  output logic o_y_step_neg,
  output logic [2:0] o_pat_row,
  output logic [2:0] o_pat_col,
  output logic o_pix_ready,
  // Pixel result
  output logic o_pix_strobe,
  output logic o_pix_we,
  output blc_pkg::blc_colour_t o_pix_result,
  output logic [DIM_W-1:0] o_pix_x,
  output logic [DIM_W-1:0] o_pix_y
);
  import blc_pkg::*;

  blc_pix_if pix ();

  logic [31:0] ctrl;
  logic [7:0] ctrl_byte [4];
  blc_state_t state;
  logic [DIM_W-1:0] x_cnt;
  logic [DIM_W-1:0] y_cnt;
  logic [DIM_W-1:0] width_r;
  logic [DIM_W-1:0] height_r;
  logic [2:0] dst_lo_r;
  logic [2:0] pat_row;
  logic [2:0] pat_col;
  logic host_full;
  blc_colour_t host_colour;
  logic host_bit;

  logic acc_ctrl;
  logic acc_port;
  logic [31:0] ctrl_read;
  logic f_solid;
  logic f_pat_mono;
  logic f_pat_mask;
  logic [2:0] f_cmp;
  logic f_src_mask;
  logic f_src_mono;
  logic f_src_host;
  blc_corner_t f_corner;
  logic [7:0] f_rop;
  logic [2:0] f_pat_row;
  logic go;
  logic step;
  logic last_x;
  logic last_y;
  logic port_take;

  // Address decode
  assign acc_ctrl = (i_mem_addr == `BLC_CTRL_OFFSET);
  assign acc_port = (i_mem_addr == `BLC_DATA_PORT_OFFSET);

  // Field views of the control register
  assign f_pat_row = ctrl[`BLC_PAT_ROW_LSB +: 3];
  assign f_solid = ctrl[`BLC_SOLID_BIT];
  assign f_pat_mono = ctrl[`BLC_PAT_MONO_BIT];
  assign f_pat_mask = ctrl[`BLC_PAT_MASK_BIT];
  assign f_cmp = ctrl[`BLC_CMP_LSB +: 3];
  assign f_src_mask = ctrl[`BLC_SRC_MASK_BIT];
  assign f_src_mono = ctrl[`BLC_SRC_MONO_BIT];
  assign f_src_host = ctrl[`BLC_SRC_HOST_BIT];
  assign f_corner = blc_corner_t'(ctrl[`BLC_CORNER_LSB +: 2]);
  assign f_rop = ctrl[`BLC_ROP_LSB +: 8];

  // Read view: busy on top, reserved bits zero
  always_comb begin
    ctrl_read = ctrl & `BLC_CTRL_WR_MASK;
    ctrl_read[`BLC_BUSY_BIT] = (state == BLC_RUN);
  end

  // Control register writes per byte lane
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      localparam logic [7:0] LANE_KEEP = 8'(`BLC_CTRL_WR_MASK >> (8 * g));
      localparam logic [7:0] LANE_RESET = 8'(`BLC_CTRL_RESET >> (8 * g));
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          ctrl_byte[g] <= LANE_RESET;
        end else if (i_mem_wr && acc_ctrl && i_mem_be[g]) begin
          ctrl_byte[g] <= i_mem_wdata[8*g +: 8] & LANE_KEEP;
        end
      end
    end
  endgenerate
  assign ctrl = {ctrl_byte[3], ctrl_byte[2], ctrl_byte[1], ctrl_byte[0]};

  // Register read data
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mem_rdata <= 32'h00000000;
    end else if (i_mem_rd) begin
      o_mem_rdata <= acc_ctrl ? ctrl_read : 32'h00000000;
    end
  end

  // Sequencing terms
  assign go = i_start && (state == BLC_IDLE) && (i_width_px != '0) && (i_height != '0);
  assign step = (state == BLC_RUN) && i_pix_valid && (!f_src_host || host_full);
  assign last_x = (x_cnt == width_r - 1'b1);
  assign last_y = (y_cnt == height_r - 1'b1);
  assign port_take = i_mem_wr && acc_port && o_data_port_ready;

  // Handshake outputs
  assign o_data_port_ready = (state == BLC_RUN) && f_src_host && !host_full;
  assign o_pix_ready = step;

  // Engine state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= BLC_IDLE;
    end else if (go) begin
      state <= BLC_RUN;
    end else if (step && last_x && last_y) begin
      state <= BLC_IDLE;
    end
  end

  // Operation size latched at start
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      width_r <= '0;
      height_r <= '0;
    end else if (go) begin
      width_r <= i_width_px;
      height_r <= i_height;
    end
  end

  // Line start column latched at start
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dst_lo_r <= 3'h0;
    end else if (go) begin
      dst_lo_r <= i_dst_addr_lo;
    end
  end

  // Pixel counter along the line
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      x_cnt <= '0;
    end else if (go) begin
      x_cnt <= '0;
    end else if (step) begin
      if (last_x) begin
        x_cnt <= '0;
      end else begin
        x_cnt <= x_cnt + 1'b1;
      end
    end
  end

  // Line counter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      y_cnt <= '0;
    end else if (go) begin
      y_cnt <= '0;
    end else if (step && last_x) begin
      y_cnt <= y_cnt + 1'b1;
    end
  end

  // Pattern row walks with the lines
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pat_row <= 3'h0;
    end else if (go) begin
      pat_row <= f_pat_row;
    end else if (step && last_x) begin
      if (f_corner[1]) begin
        pat_row <= pat_row - 3'h1;
      end else begin
        pat_row <= pat_row + 3'h1;
      end
    end
  end

  // Pattern column from destination address low bits
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pat_col <= 3'h0;
    end else if (go) begin
      pat_col <= i_dst_addr_lo;
    end else if (step) begin
      if (last_x) begin
        pat_col <= dst_lo_r;
      end else if (f_corner[0]) begin
        pat_col <= pat_col - 3'h1;
      end else begin
        pat_col <= pat_col + 3'h1;
      end
    end
  end

  // Host data port holding flag
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      host_full <= 1'b0;
    end else if (go) begin
      host_full <= 1'b0;
    end else if (port_take) begin
      host_full <= 1'b1;
    end else if (step) begin
      host_full <= 1'b0;
    end
  end

  // Host data port word
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      host_colour <= '0;
      host_bit <= 1'b0;
    end else if (port_take) begin
      host_colour <= i_mem_wdata[23:0];
      host_bit <= i_mem_wdata[`BLC_HOST_MONO_BIT];
    end
  end

  // Operands to the evaluator
  assign pix.solid_pat = f_solid;
  assign pix.pat_mono = f_pat_mono;
  assign pix.pat_mask = f_pat_mask;
  assign pix.cmp = f_cmp;
  assign pix.src_mask = f_src_mask;
  assign pix.src_mono = f_src_mono;
  assign pix.src_pair_sel = i_src_pair_sel;
  assign pix.rop = f_rop;
  assign pix.bpp = i_bpp;
  assign pix.pat_row_bits = i_pat_row_bits;
  assign pix.pat_col = pat_col;
  assign pix.pat_colour = i_pat_colour;
  assign pix.pat_bg = i_pat_bg;
  assign pix.pat_fg = i_pat_fg;
  assign pix.src_bg = i_src_bg;
  assign pix.src_fg = i_src_fg;
  assign pix.src_bit = f_src_host ? host_bit : i_fb_src_bit;
  assign pix.src_colour = f_src_host ? host_colour : i_fb_src_colour;
  assign pix.dst_colour = i_dst_colour;

  blc_pixel u_pixel (
    .pix(pix)
  );

  // Pixel strobe and write enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pix_strobe <= 1'b0;
      o_pix_we <= 1'b0;
    end else begin
      o_pix_strobe <= step;
      o_pix_we <= step && pix.we;
    end
  end

  // Registered pixel result and position
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pix_result <= '0;
      o_pix_x <= '0;
      o_pix_y <= '0;
    end else if (step) begin
      o_pix_result <= pix.result;
      o_pix_x <= x_cnt;
      o_pix_y <= y_cnt;
    end
  end

  // Busy copy of the status bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= ctrl_read[`BLC_BUSY_BIT];
    end
  end

  // Operand fetch enables
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pat_fetch_en <= 1'b0;
      o_src_fetch_fb <= 1'b0;
    end else begin
      o_pat_fetch_en <= !(f_pat_mono && f_solid);
      o_src_fetch_fb <= !f_src_host;
    end
  end

  // Scan directions from the starting corner
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_x_step_neg <= 1'b0;
      o_y_step_neg <= 1'b0;
    end else begin
      o_x_step_neg <= f_corner[0];
      o_y_step_neg <= f_corner[1];
    end
  end

  assign o_pat_row = pat_row;
  assign o_pat_col = pat_col;

endmodule // blc_top

// *** dv/blc_checker_assertions.sv ***
// Concurrent checks on the ports of the blit control top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module blc_checker #(
  parameter int DIM_W = 13
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register access
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [23:0] i_mem_addr,
  input wire logic [3:0] i_mem_be,
  input wire logic [31:0] i_mem_wdata,
  input wire logic [31:0] o_mem_rdata,
  input wire logic o_data_port_ready,
  // Operation
  input wire logic i_start,
  input wire logic [DIM_W-1:0] i_width_px,
  input wire logic [DIM_W-1:0] i_height,
  input wire logic i_pix_valid,
  input wire logic o_busy,
  input wire logic o_pat_fetch_en,
  input wire logic o_src_fetch_fb,
  input wire logic o_x_step_neg,
  input wire logic o_y_step_neg,
  input wire logic o_pix_ready,
  input wire logic o_pix_strobe,
  input wire logic o_pix_we
);
  logic wr_any;
  logic wr_full;
  logic [31:0] wq;
  assign wr_any = i_mem_wr && i_mem_addr == 24'h400010;
  assign wr_full = wr_any && i_mem_be == 4'hF;
  // Last full control write
  always_ff @(posedge i_clk) begin
    if (wr_full) begin
      wq <= i_mem_wdata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_rsvd_read_zero: assert property (
    i_mem_rd |=> o_mem_rdata[30:23] == 8'h00 && !o_mem_rdata[11]) else $error("reserved set");
  a_corner_copy: assert property (
    wr_full ##1 !wr_any |=> o_x_step_neg == wq[8] && o_y_step_neg == wq[9])
    else $error("corner steps wrong");
  a_src_fetch_sel: assert property (
    wr_full ##1 !wr_any |=> o_src_fetch_fb == !wq[10]) else $error("source fetch wrong");
  a_solid_no_fetch: assert property (
    wr_full ##1 !wr_any |=> o_pat_fetch_en == !(wq[19] && wq[18]))
    else $error("pattern fetch wrong");
  a_strobe_follows: assert property (
    o_pix_ready |=> o_pix_strobe) else $error("strobe missing");
  a_strobe_cause: assert property (
    o_pix_strobe |-> $past(o_pix_ready)) else $error("stray strobe");
  a_we_with_strobe: assert property (
    o_pix_we |-> o_pix_strobe) else $error("write without strobe");
  a_port_take: assert property (
    o_data_port_ready && i_mem_wr && i_mem_addr == 24'h400100 |=> !o_data_port_ready)
    else $error("port stage not taken");
  a_start_busy: assert property (
    !o_busy && i_start && i_width_px != 0 && i_height != 0 |-> ##[1:3] o_busy)
    else $error("start ignored");
  a_zero_refused: assert property (
    !o_busy && i_start && i_width_px == 0 |=> !o_busy [*3]) else $error("zero start ran");
endmodule // blc_checker

bind blc_top blc_checker #(.DIM_W(DIM_W)) u_chk (
  .i_clk, .i_srst, .i_mem_wr, .i_mem_rd, .i_mem_addr, .i_mem_be, .i_mem_wdata, .o_mem_rdata,
  .o_data_port_ready, .i_start, .i_width_px, .i_height, .i_pix_valid, .o_busy, .o_pat_fetch_en,
  .o_src_fetch_fb, .o_x_step_neg, .o_y_step_neg, .o_pix_ready, .o_pix_strobe, .o_pix_we
);

// *** dv/blc_host_model.sv ***
// Host software model: register reads and writes, data-port pixel writes.
// Assumes requests start just after a rising edge of i_clk.
`timescale 1ns/100ps
module blc_host_model (
  // Clock
  input wire logic i_clk,
  // Memory bus to the device
  output logic o_wr,
  output logic o_rd,
  output logic [23:0] o_addr,
  output logic [3:0] o_be,
  output logic [31:0] o_wdata,
  input wire logic [31:0] i_rdata,
  input wire logic i_port_ready
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 24'h000000;
    o_be = 4'h0;
    o_wdata = 32'h00000000;
  end
  // One request cycle, then the bus is released
  task automatic acc(input logic w, input logic [23:0] a, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk) #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_be = be;
    o_wdata = wd;
    @(posedge i_clk) #1;
    rd = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~wd;
  endtask
  // Poll readiness, then one word per pixel
  task automatic push(input logic [31:0] wd, output logic ok);
    logic [31:0] x;
    ok = 1'b0;
    for (int t = 0; t < 50 && !ok; t++) begin
      @(posedge i_clk) #1;
      ok = (i_port_ready === 1'b1);
    end
    if (ok) begin
      acc(1'b1, 24'h400100, 4'hF, wd, x);
    end
  endtask
endmodule // blc_host_model

// *** dv/tb_top.sv ***
// Testbench for the blit control top: register, pixel and host-port sequences.
// Assumes the host model owns the memory bus and the bench all other inputs.
`timescale 1ns/100ps
module tb_top;
  import blc_pkg::*;
  localparam logic [23:0] CTRL_A = 24'h400010;
  localparam logic [23:0] P = 24'hF0F00F;
  localparam logic [23:0] S = 24'hCCCC33;
  localparam logic [23:0] D = 24'hAAAA55;
  logic i_clk, i_srst, i_start, i_pix_valid, i_fb_src_bit, i_src_pair_sel, we, m, ok;
  logic i_mem_wr, i_mem_rd, o_data_port_ready, o_busy, o_pat_fetch_en, o_src_fetch_fb;
  logic o_x_step_neg, o_y_step_neg, o_pix_ready, o_pix_strobe, o_pix_we;
  logic [23:0] i_mem_addr;
  logic [3:0] i_mem_be;
  logic [31:0] i_mem_wdata, o_mem_rdata, d;
  logic [12:0] i_width_px, i_height, o_pix_x, o_pix_y;
  logic [2:0] i_dst_addr_lo, o_pat_row, o_pat_col;
  logic [7:0] i_pat_row_bits;
  logic [7:0] rops [8] = '{8'h00, 8'hFF, 8'hF0, 8'hCC, 8'hAA, 8'h5A, 8'h66, 8'h88};
  blc_bpp_t i_bpp;
  blc_colour_t i_pat_bg, i_pat_fg, i_src_bg, i_src_fg, i_pat_colour, i_fb_src_colour;
  blc_colour_t i_dst_colour, o_pix_result, res, bg;
  logic [25:0] xy;
  int errors, n_checks;

  blc_top uut (
    .i_clk, .i_srst, .i_mem_wr, .i_mem_rd, .i_mem_addr, .i_mem_be, .i_mem_wdata, .o_mem_rdata,
    .o_data_port_ready, .i_start, .i_width_px, .i_height, .i_dst_addr_lo, .i_bpp,
    .i_src_pair_sel, .i_pat_bg, .i_pat_fg, .i_src_bg, .i_src_fg, .i_pix_valid, .i_pat_row_bits,
    .i_pat_colour, .i_fb_src_bit, .i_fb_src_colour, .i_dst_colour, .o_busy, .o_pat_fetch_en,
    .o_src_fetch_fb, .o_x_step_neg, .o_y_step_neg, .o_pat_row, .o_pat_col, .o_pix_ready,
    .o_pix_strobe, .o_pix_we, .o_pix_result, .o_pix_x, .o_pix_y
  );
  blc_host_model host (.i_clk, .o_wr(i_mem_wr), .o_rd(i_mem_rd), .o_addr(i_mem_addr),
    .o_be(i_mem_be), .o_wdata(i_mem_wdata), .i_rdata(o_mem_rdata),
    .i_port_ready(o_data_port_ready));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [23:0] rop_f(input logic [7:0] r, input logic [23:0] p, s, t);
    for (int i = 0; i < 24; i++) rop_f[i] = r[{p[i], s[i], t[i]}];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] v);
    host.acc(1'b1, CTRL_A, 4'hF, v, d);
  endtask
  task automatic rd(input logic [23:0] a);
    host.acc(1'b0, a, 4'hF, 32'h0, d);
  endtask
  task automatic st(input logic [12:0] w);
    @(posedge i_clk) #1;
    i_start = 1'b1;
    i_width_px = w;
    @(posedge i_clk) #1;
    i_start = 1'b0;
  endtask
  // Collect n pixel strobes, keeping the last result
  task automatic wt(input int n);
    int k;
    k = 0;
    for (int t = 0; t < 200 && k < n; t++) begin
      @(posedge i_clk) #1;
      if (o_pix_strobe === 1'b1) begin
        k++;
        res = o_pix_result;
        we = o_pix_we;
        xy = {o_pix_y, o_pix_x};
      end
    end
    if (k < n) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic run(input logic [31:0] v);
    wr(v);
    st(13'h0001);
    wt(1);
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    i_srst = 1'b1;
    i_start = 1'b0;
    i_width_px = 13'h0001;
    i_height = 13'h0001;
    i_dst_addr_lo = 3'h0;
    i_bpp = BLC_BPP24;
    i_src_pair_sel = 1'b1;
    i_pat_bg = D;
    i_pat_fg = 24'h222222;
    i_src_bg = S;
    i_src_fg = 24'h333333;
    i_pix_valid = 1'b1;
    i_pat_row_bits = 8'h00;
    i_pat_colour = P;
    i_fb_src_bit = 1'b0;
    i_fb_src_colour = S;
    i_dst_colour = D;
    repeat (8) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    rd(CTRL_A);
    chk("ctrl reset", 32'h00000000, d);
    wr(32'hFFFFFFFF);
    rd(CTRL_A);
    chk("ctrl readback", 32'h007FF7FF, d);
    rd(24'h400100);
    chk("port read", 32'h00000000, d);
    for (int c = 0; c < 4; c++) begin
      wr(32'(c) << 8);
      @(posedge i_clk) #1;
      chk("corner", 32'(c), {30'h0, o_y_step_neg, o_x_step_neg});
    end
    i_pix_valid = 1'b0;
    i_dst_addr_lo = 3'h3;
    i_height = 13'h0002;
    wr(32'h005000F0);
    st(13'h0002);
    rd(CTRL_A);
    chk("busy bit", 32'h805000F0, d);
    chk("pat row", 32'h5, {29'h0, o_pat_row});
    chk("pat col", 32'h3, {29'h0, o_pat_col});
    i_pix_valid = 1'b1;
    wt(4);
    chk("pat row step", 32'h7, {29'h0, o_pat_row});
    chk("last pixel", 32'h00002001, {6'h0, xy});
    i_height = 13'h0001;
    rd(CTRL_A);
    chk("idle bit", 32'h005000F0, d);
    st(13'h0000);
    rd(CTRL_A);
    chk("zero width", 32'h005000F0, d);
    i_dst_addr_lo = 3'h0;
    foreach (rops[i]) begin
      run({24'h0, rops[i]});
      chk("rop result", {8'h0, rop_f(rops[i], P, S, D)}, {8'h0, res});
      chk("rop write", 32'h1, {31'h0, we});
    end
    for (int c = 0; c < 16; c++) begin
      i_src_pair_sel = c[3];
      bg = c[3] ? S : D;
      m = c[1] ? (D == bg) : (S == bg);
      run((32'(c[2:0]) << 14) | 32'h000000CC);
      chk("cmp result", {8'h0, S}, {8'h0, res});
      chk("cmp write", {31'h0, !c[0] || (c[2] ? m : !m)}, {31'h0, we});
    end
    i_pat_bg = 24'h111111;
    run(32'h000600F0);
    chk("pat mask", 32'h0, {31'h0, we});
    i_pat_row_bits = 8'hFF;
    run(32'h000600F0);
    chk("mono pat", 32'h00222222, {8'h0, res});
    run(32'h000C00F0);
    chk("solid pat", 32'h00111111, {8'h0, res});
    chk("pat fetch", 32'h0, {31'h0, o_pat_fetch_en});
    run(32'h000030CC);
    chk("src mask", 32'h0, {31'h0, we});
    i_fb_src_bit = 1'b1;
    run(32'h000030CC);
    chk("mono src", 32'h00333333, {8'h0, res});
    i_src_pair_sel = 1'b0;
    run(32'h000010CC);
    chk("shared pair", 32'h00222222, {8'h0, res});
    fork
      run(32'h000004CC);
      host.push(32'h00ABCDEF, ok);
    join
    chk("host taken", 32'h1, {31'h0, ok});
    chk("host pixel", 32'h00ABCDEF, {8'h0, res});
    chk("fb fetch off", 32'h0, {31'h0, o_src_fetch_fb});
    finish_test();
  end
endmodule // tb_top
